// file: logic/burst_sram_defines.svh
`ifndef BURST_SRAM_DEFINES_SVH
`define BURST_SRAM_DEFINES_SVH

// Geometry of the widest organisation
`define LANE_WIDTH      9
`define MAX_LANES       4
`define DEF_LANES       4
`define DEF_EXT_ADDR_W  19

// Burst shape
`define BURST_COUNT     2
`define BEAT0_LSB       1'h0
`define BEAT1_LSB       1'h1

`endif

// file: logic/burst_sram_pkg.sv
package burst_sram_pkg;

  // Write bus-cycle state
  typedef enum logic [0:0] {
    WR_IDLE  = 1'b0,
    WR_BEAT1 = 1'b1
  } wr_state_t;

endpackage

// file: logic/lane_sram_mem.sv
`timescale 1ns/10ps

module lane_sram_mem #(
  parameter int AW    = 20,
  parameter int LANES = 4,
  parameter int LW    = 9
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // Write port
  input  wire logic                wr_en,
  input  wire logic [AW-1:0]       wr_addr,
  input  wire logic [LANES*LW-1:0] wr_data,
  input  wire logic [LANES-1:0]    wr_lane_en,
  // Read port
  input  wire logic                rd_en,
  input  wire logic [AW-1:0]       rd_addr,
  output logic      [LANES*LW-1:0] rd_data
);

  // One array per lane, so each store has a single writing process and an
  // unselected lane keeps its old contents
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    logic [LW-1:0] lane_mem [0:(1<<AW)-1];

    // Lane write, only while this lane is enabled
    always_ff @(posedge clk_sys) begin
      if (wr_en && wr_lane_en[i]) begin
        lane_mem[wr_addr] <= wr_data[i*LW +: LW];
      end
    end

    // Registered lane read; holds the last word until the next read
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        rd_data[i*LW +: LW] <= '0;
      end else if (rd_en) begin
        rd_data[i*LW +: LW] <= lane_mem[rd_addr];
      end
    end
  end

endmodule // lane_sram_mem

// file: logic/burst_sram_byte_write_core.sv
`timescale 1ns/10ps
`include "burst_sram_defines.svh"

// Operation
// (RL1) Nine-bit part: one low lane select stores the beat, high stores nothing.
// (RL2) Eighteen-bit part: two lane selects, bits 0-8 and bits 9-17.
// (RL3) Thirty-six-bit part: four lane selects, one per nine-bit lane.
// (RL4) Lane selects are taken fresh with each beat of a burst.
// (RL5) Lane selects act only during the beats of a started write.
// (RL6) Burst address gets one internal low bit picking the word.
// (RL7) Burst words always go base plus zero, then base plus one.
// (RL8) Every read or write bus cycle ends after exactly two beats.
// (RL9) Read and write machines are separate and may run together.
// (RL10) Both machines advance on the primary input clock edge; the code also steps the write machine back to idle on K#.
// (RL11) Write: select low at K edge, beats at K and next K#.
// (RL12) Read: select low at K, words on next K# and following K; the code drives them on the second K# and the K after it.
// (RL13) Both selects high: no operation, outputs released.
// (RL14) Control inputs are registered only at the primary clock edge.
module burst_sram_byte_write_core #(
  parameter int LANES      = `DEF_LANES,
  parameter int EXT_ADDR_W = `DEF_EXT_ADDR_W
) (
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  // Input clock pair edges, one-cycle strobes
  input  wire logic                          k_rise,
  input  wire logic                          kn_rise,
  // Controls and address
  input  wire logic                          read_sel_n,
  input  wire logic                          write_sel_n,
  input  wire logic [EXT_ADDR_W-1:0]         addr,
  // Write data and lane masks
  input  wire logic [LANES*`LANE_WIDTH-1:0]  d,
  input  wire logic                          lane0_write_mask_n,
  input  wire logic                          lane1_write_mask_n,
  input  wire logic                          lane2_write_mask_n,
  input  wire logic                          lane3_write_mask_n,
  // Read data pin as output and enable
  output logic      [LANES*`LANE_WIDTH-1:0]  q_data,
  output logic                               q_oe
);

  localparam int DW = LANES * `LANE_WIDTH;
  localparam int AW = EXT_ADDR_W + 1;

  burst_sram_pkg::wr_state_t wr_state_reg;
  logic [EXT_ADDR_W-1:0]     wr_base_reg;
  logic                      rd_pend_reg;
  logic [EXT_ADDR_W-1:0]     rd_pend_addr_reg;
  logic                      rd_act_reg;
  logic [EXT_ADDR_W-1:0]     rd_act_addr_reg;
  logic [`MAX_LANES-1:0]     mask_all_n;
  logic [LANES-1:0]          lane_en;
  logic                      wr_beat0;
  logic                      wr_beat1;
  logic                      wr_en;
  logic [AW-1:0]             wr_addr;
  logic                      rd_en;
  logic [AW-1:0]             rd_addr;
  logic [DW-1:0]             rd_data;

  // Lanes above the organisation width are simply not looked at
  assign mask_all_n = {lane3_write_mask_n, lane2_write_mask_n,
                       lane1_write_mask_n, lane0_write_mask_n};

  // Active-low select per lane, sampled with whichever beat is live
  for (genvar i = 0; i < LANES; i++) begin : g_mask
    assign lane_en[i] = ~mask_all_n[i]; // RL1 RL2 RL3 RL4
  end

  // Beat strobes; masks are ignored outside them
  assign wr_beat0 = k_rise && !write_sel_n; // RL11 RL14
  assign wr_beat1 = kn_rise && (wr_state_reg == burst_sram_pkg::WR_BEAT1); // RL11
  assign wr_en    = wr_beat0 || wr_beat1; // RL5

  // Word within burst comes from the internal low bit
  assign wr_addr = wr_beat1 ? {wr_base_reg, `BEAT1_LSB} // RL6 RL7
                            : {addr, `BEAT0_LSB};

  // Write machine: opened at K, closed by the K# beat
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_state_reg <= burst_sram_pkg::WR_IDLE;
      wr_base_reg  <= '0;
    end else begin
      case (wr_state_reg)
        burst_sram_pkg::WR_IDLE: begin
          if (wr_beat0) begin // RL10
            wr_state_reg <= burst_sram_pkg::WR_BEAT1;
            wr_base_reg  <= addr;
          end
        end
        burst_sram_pkg::WR_BEAT1: begin
          if (wr_beat0) begin // Back-to-back burst, K# beat missed
            wr_base_reg <= addr;
          end else if (kn_rise) begin
            wr_state_reg <= burst_sram_pkg::WR_IDLE; // RL8
          end
        end
        default: begin
          wr_state_reg <= burst_sram_pkg::WR_IDLE;
        end
      endcase
    end
  end

  // Read pipeline: request stage, then delivery stage, both on K
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend_reg      <= 1'b0;
      rd_pend_addr_reg <= '0;
      rd_act_reg       <= 1'b0;
      rd_act_addr_reg  <= '0;
    end else if (k_rise) begin // RL9 RL10 RL14
      rd_pend_reg      <= !read_sel_n; // RL13
      rd_pend_addr_reg <= addr;
      rd_act_reg       <= rd_pend_reg; // RL8
      rd_act_addr_reg  <= rd_pend_addr_reg;
    end
  end

  // Array reads run on the K or K# edge before each output edge
  assign rd_en   = (k_rise && rd_pend_reg) || (kn_rise && rd_act_reg);
  assign rd_addr = kn_rise ? {rd_act_addr_reg, `BEAT1_LSB} // RL6 RL7
                           : {rd_pend_addr_reg, `BEAT0_LSB};

  // Output words: first on K#, second on the next K
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q_data <= '0;
      q_oe   <= 1'b0;
    end else if (kn_rise) begin
      q_oe <= rd_act_reg; // RL12 RL13
      if (rd_act_reg) begin
        q_data <= rd_data;
      end
    end else if (k_rise && rd_act_reg) begin
      q_data <= rd_data; // RL12
    end
  end

  lane_sram_mem #(
    .AW    (AW),
    .LANES (LANES),
    .LW    (`LANE_WIDTH)
  ) u_mem (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .wr_en      (wr_en),
    .wr_addr    (wr_addr),
    .wr_data    (d),
    .wr_lane_en (lane_en),
    .rd_en      (rd_en),
    .rd_addr    (rd_addr),
    .rd_data    (rd_data)
  );

  // Checks
  // Beat counters used only by the checks below; counting the beats lets
  // the burst length be checked without long repetitions in a property
  logic [1:0] wr_beat_cnt_reg;
  logic [1:0] rd_beat_cnt_reg;

  // Write beats of the open burst; a K edge that starts nothing clears it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_beat_cnt_reg <= 2'h0;
    end else if (wr_beat0) begin
      wr_beat_cnt_reg <= 2'h1;
    end else if (wr_beat1) begin
      wr_beat_cnt_reg <= wr_beat_cnt_reg + 2'h1;
    end else if (k_rise) begin
      wr_beat_cnt_reg <= 2'h0;
    end
  end

  // Read words handed out; restarts at each K# edge of a delivery
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_beat_cnt_reg <= 2'h0;
    end else if (kn_rise) begin
      rd_beat_cnt_reg <= rd_act_reg ? 2'h1 : 2'h0;
    end else if (k_rise && rd_act_reg) begin
      rd_beat_cnt_reg <= rd_beat_cnt_reg + 2'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence seq_wr_start;
    k_rise && !write_sel_n;
  endsequence

  // The host leaves one idle clk_sys between K and K#; other pacings
  // simply do not match the sequences built on this gap
  sequence seq_gap;
    !k_rise && !kn_rise;
  endsequence

  sequence seq_rd_start;
    k_rise && !read_sel_n;
  endsequence

  // K# edge at which the first read word goes out
  sequence seq_rd_word0;
    kn_rise && rd_act_reg;
  endsequence

  // Write path
  wr_first_a: assert property (seq_wr_start |-> wr_en && !wr_addr[0] // RL11
                               && wr_addr[AW-1:1] == addr)
    else $error("first write beat not at base plus zero");

  // Second beat two clk_sys later, at base plus one; the address is
  // the one of the start edge, not whatever addr shows by then
  wr_second_a: assert property (seq_wr_start ##1 seq_gap ##1 kn_rise // RL7
                                |-> wr_en && wr_addr[0]
                                && wr_addr[AW-1:1] == $past(addr, 2))
    else $error("second write beat not at base plus one");

  // The base kept for the K# beat is the address of the start edge
  wr_base_a: assert property (seq_wr_start |=> wr_base_reg == $past(addr)) // RL6
    else $error("write base address not loaded");

  // K# beat closes the burst, so a third beat can never land
  burst_end_a: assert property (kn_rise && !k_rise && wr_state_reg == burst_sram_pkg::WR_BEAT1 // RL8
                                |=> wr_state_reg == burst_sram_pkg::WR_IDLE)
    else $error("write burst did not end after two beats");

  // A K# edge with no open burst must not write: masks and data are
  // junk from the host's point of view then
  wr_stray_a: assert property (kn_rise && !k_rise // RL5
                               && wr_state_reg == burst_sram_pkg::WR_IDLE |-> !wr_en)
    else $error("write beat with no open burst");

  lane_map_a: assert property (wr_en |-> lane_en == ~mask_all_n[LANES-1:0]) // RL1
    else $error("lane enables do not follow masks");

  mask_idle_a: assert property (wr_en |-> k_rise || kn_rise) // RL5
    else $error("write outside a beat");

  // A quiet clk_sys cycle is neither a K nor a K# edge: nothing may move
  quiet_cycle_a: assert property (!k_rise && !kn_rise |-> !wr_en && !rd_en) // RL14
    else $error("array touched between clock edges");

  // Read path
  rd_load_a: assert property (seq_rd_start |=> rd_pend_reg // RL14
                              && rd_pend_addr_reg == $past(addr))
    else $error("read request not loaded");

  // Array reads run on the K or K# edge before the output edge, word by word
  rd_first_addr_a: assert property (k_rise && rd_pend_reg |-> rd_en && !rd_addr[0] // RL7
                                    && rd_addr[AW-1:1] == rd_pend_addr_reg)
    else $error("first read word not at base plus zero");

  rd_second_addr_a: assert property (seq_rd_word0 |-> rd_en && rd_addr[0] // RL7
                                     && rd_addr[AW-1:1] == rd_act_addr_reg)
    else $error("second read word not at base plus one");

  rd_beat0_a: assert property (seq_rd_word0 |=> q_oe // RL12
                               && q_data == $past(rd_data))
    else $error("first read word not driven");

  // Second word on the K that follows the K# of the first
  rd_beat1_a: assert property (seq_rd_word0 ##1 seq_gap ##1 k_rise // RL12
                               |=> q_oe && q_data == $past(rd_data))
    else $error("second read word not driven");

  nop_oe_a: assert property (kn_rise && !rd_act_reg |=> !q_oe) // RL13
    else $error("output driven with no read");

  // Output enable and data stand until their own edge comes round
  oe_hold_a: assert property (!kn_rise |=> $stable(q_oe)) // RL12
    else $error("output enable moved off a K# edge");

  q_hold_a: assert property (!k_rise && !kn_rise |=> $stable(q_data)) // RL12
    else $error("read data moved between clock edges");

  // A read and a write started on one K edge both proceed
  dual_run_a: assert property (k_rise && !read_sel_n && !write_sel_n // RL9
                               |=> rd_pend_reg && wr_state_reg == burst_sram_pkg::WR_BEAT1)
    else $error("read and write did not start together");

  k_only_a: assert property (!k_rise |=> $stable(rd_pend_reg) && $stable(rd_act_reg)) // RL10
    else $error("read machine moved off the primary edge");

  // Burst length, counted in the helpers above
  // Counting avoids a repetition spanning the whole burst
  wr_count_a: assert property (wr_beat1 |=> wr_beat_cnt_reg == 2'(`BURST_COUNT)) // RL8
    else $error("write burst closed after a wrong beat count");

  rd_count_a: assert property (k_rise && rd_act_reg // RL8
                               |=> rd_beat_cnt_reg == 2'(`BURST_COUNT))
    else $error("read burst closed after a wrong beat count");

  beat_cap_a: assert property (wr_beat_cnt_reg <= 2'(`BURST_COUNT) // RL8
                               && rd_beat_cnt_reg <= 2'(`BURST_COUNT))
    else $error("burst ran past two beats");

endmodule // burst_sram_byte_write_core

// file: verification/host_clock_model.sv
`timescale 1ns/10ps
// Host controller side: the K and K# rising edges as one-cycle strobes
module host_clock_model (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Clock pair edge strobes
  output logic      k_rise,
  output logic      kn_rise
);
  logic [1:0] phase_reg;
  // Moved on the falling edge so the strobes are settled at the sampling edge
  always_ff @(negedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 2'h3;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end
  // K and K# alternate with an idle cycle between them; quiet in reset
  assign k_rise  = rst_n && (phase_reg == 2'h0);
  assign kn_rise = rst_n && (phase_reg == 2'h2);
endmodule // host_clock_model

// file: verification/burst_sram_byte_write_core_tb_top.sv
`timescale 1ns/10ps
module burst_sram_byte_write_core_tb_top;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        k_rise, kn_rise, read_sel_n = 1'b1, write_sel_n = 1'b1;
  logic [18:0] addr = 19'h0;
  logic [35:0] d = 36'h0, q_data, exp_mem [0:31];
  logic [3:0]  mask_n = 4'hF;
  logic        q_oe;
  int          mismatches = 0, num_checks = 0, cycles = 0;

  burst_sram_byte_write_core uut (.clk_sys(clk_sys), .rst_n(rst_n), .k_rise(k_rise),
    .kn_rise(kn_rise), .read_sel_n(read_sel_n), .write_sel_n(write_sel_n), .addr(addr),
    .d(d), .lane0_write_mask_n(mask_n[0]), .lane1_write_mask_n(mask_n[1]),
    .lane2_write_mask_n(mask_n[2]), .lane3_write_mask_n(mask_n[3]), .q_data(q_data),
    .q_oe(q_oe));
  host_clock_model host (.clk_sys(clk_sys), .rst_n(rst_n), .k_rise(k_rise), .kn_rise(kn_rise));

  always #5 clk_sys = ~clk_sys;
  // Cut a hang short well past the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic check(string name, logic [35:0] seen, logic [35:0] expected);
    num_checks++;
    if (seen !== expected) begin
      $display("unexpected %s expected %h seen %h", name, expected, seen);
      mismatches++;
    end
  endtask
  // Leaves us at the falling edge just before a K strobe is sampled
  task automatic wait_k();
    @(posedge clk_sys iff kn_rise);
    @(negedge clk_sys);
    @(negedge clk_sys);
  endtask
  // Burst write; junk data and open masks between bursts must be ignored
  task automatic wr(logic [18:0] a, logic [35:0] d0, logic [3:0] m0, logic [35:0] d1,
                    logic [3:0] m1);
    wait_k();
    write_sel_n = 1'b0;
    addr = a;
    d = d0;
    mask_n = m0;
    @(negedge clk_sys);
    write_sel_n = 1'b1;
    d = d1;
    mask_n = m1;
    @(posedge clk_sys iff kn_rise);
    @(negedge clk_sys);
    d = ~d1;
    mask_n = 4'h0;
    for (int l = 0; l < 4; l++) begin
      if (!m0[l]) exp_mem[a*2][9*l+:9] = d0[9*l+:9];
      if (!m1[l]) exp_mem[a*2+1][9*l+:9] = d1[9*l+:9];
    end
  endtask
  // Burst read: word base+0 after the second K#, base+1 after the next K
  task automatic rd(logic [18:0] a);
    wait_k();
    read_sel_n = 1'b0;
    addr = a;
    @(negedge clk_sys);
    read_sel_n = 1'b1;
    repeat (2) @(posedge clk_sys iff kn_rise);
    @(posedge clk_sys);
    @(negedge clk_sys);
    check("q_oe", {35'h0, q_oe}, 36'h1);
    check("word0", q_data, exp_mem[a*2]);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check("word1", q_data, exp_mem[a*2+1]);
  endtask

  task automatic t_full();
    wr(19'h5, 36'h123456789, 4'h0, 36'hABCDEF012, 4'h0);
    rd(19'h5);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check("q_oe idle", {35'h0, q_oe}, 36'h0);
    $display("test full burst done");
  endtask
  // Each lane alone, with a different lane in each beat
  task automatic t_lanes();
    wr(19'h9, 36'h0, 4'h0, 36'hFFFFFFFFF, 4'h0);
    for (int i = 0; i < 4; i++) begin
      wr(19'h9, {4{9'h1A0 + 9'(i)}}, ~(4'h1 << i), {4{9'h055 + 9'(i)}}, ~(4'h8 >> i));
      rd(19'h9);
    end
    $display("test lane masks done");
  endtask
  // Read in flight while a write runs; a select at K# must do nothing
  task automatic t_conc();
    fork
      rd(19'h5);
      begin
        @(posedge clk_sys iff k_rise);
        wr(19'h7, 36'h0F0F0F0F0, 4'h0, 36'h3C3C3C3C3, 4'h0);
      end
    join
    rd(19'h7);
    @(posedge clk_sys iff k_rise);
    @(negedge clk_sys);
    @(negedge clk_sys);
    write_sel_n = 1'b0;
    read_sel_n = 1'b0;
    addr = 19'h5;
    @(negedge clk_sys);
    write_sel_n = 1'b1;
    read_sel_n = 1'b1;
    rd(19'h5);
    $display("test concurrent and K# select done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    t_full();
    t_lanes();
    t_conc();
    give_verdict();
  end
endmodule // burst_sram_byte_write_core_tb_top
